/* gpio_port_params.svh */
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFF_DIR 8'h00
`define OFF_OUT 8'h04
`define OFF_OPEN_DRAIN 8'h08
`define OFF_OPEN_SOURCE 8'h0C
`define OFF_FILTER_EN 8'h10
`define OFF_PIN_LEVEL 8'h14
`define OFF_RISE_EN 8'h18
`define OFF_FALL_EN 8'h1C
`define OFF_INT_FLAG 8'h20
`define OFF_INT_MASK 8'h24
`define OFF_WAKE_EN 8'h28
`define OFF_WAKE_STAT 8'h2C
`define OFF_POWER_STAT 8'h30
`define OFF_ROUTE0 8'h40

// ----------------------------------------------------------------
// Fields, reset values and counts
// ----------------------------------------------------------------
`define ROUTE_SEL_W 5
`define ROUTE_EN_BIT 8
`define RST_WORD 32'h0000_0000
`define FILTER_SAMPLES 3
`define DEFAULT_PINS 26
`define DEFAULT_AB_PINS 16
`define DEFAULT_CONNS 4
`define DEFAULT_WAKE_PINS 32'h0000_0C03

`endif

/* gpio_port_pkg.sv */
package gpio_port_pkg;
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_DEEP,
    PWR_SHUT
  } pwr_state_t;
endpackage

/* general_purpose_pin_port.sv */
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "gpio_port_params.svh"
module general_purpose_pin_port
  import gpio_port_pkg::*;
#(
  parameter int NPINS = `DEFAULT_PINS,
  parameter int AB_PINS = `DEFAULT_AB_PINS,
  parameter int NCONN = `DEFAULT_CONNS,
  parameter int FILT_LEN = `FILTER_SAMPLES,
  parameter logic [31:0] WAKE_PINS = `DEFAULT_WAKE_PINS
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [31:0] rdata_o,
  input wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0] pin_o,
  output logic [NPINS-1:0] pin_oe_o,
  input wire logic [NCONN-1:0] conn_out_i,
  input wire logic [NCONN-1:0] conn_oe_i,
  output logic [NCONN-1:0] conn_in_o,
  output logic [NPINS-1:0] peripheral_event_network_o,
  input wire logic deep_sleep_mode_i,
  input wire logic stop_mode_i,
  input wire logic shutdown_mode_i,
  output logic irq_o,
  output logic wake_o,
  output logic shutdown_wake_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  generate
    if (NPINS < 1 || NPINS > 32 || AB_PINS > NPINS || NCONN < 2 || NCONN > 8 || FILT_LEN < 2) begin : g_bad
      $error("general_purpose_pin_port: unsupported parameter values");
    end
  endgenerate

  logic [NPINS-1:0] dir, out, odrain, osrc, filt_en, rise_en, fall_en, mask, wake_en;
  logic [NPINS-1:0] flag, wake_flag;
  logic [NPINS-1:0] sync1, sync2, filt, lvl, lvl_prev;
  logic [NPINS-1:0] edge_set, edge_any, ab_mask, next_o, next_oe, ovr;
  logic [`ROUTE_SEL_W-1:0] route_sel [NCONN];
  logic [NCONN-1:0] route_en;
  pwr_state_t pwr_state, next_pwr_state;
  logic flag_rd, wake_rd;
  logic [NPINS-1:0] flag_wclr, wake_wclr;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      dir <= NPINS'(`RST_WORD);
      out <= NPINS'(`RST_WORD);
      odrain <= NPINS'(`RST_WORD);
      osrc <= NPINS'(`RST_WORD);
      filt_en <= NPINS'(`RST_WORD);
      rise_en <= NPINS'(`RST_WORD);
      fall_en <= NPINS'(`RST_WORD);
      mask <= NPINS'(`RST_WORD);
      wake_en <= NPINS'(`RST_WORD);
    end else if (we_i) begin
      case (addr_i)
        `OFF_DIR: dir <= wdata_i[NPINS-1:0];
        `OFF_OUT: out <= wdata_i[NPINS-1:0];
        `OFF_OPEN_DRAIN: odrain <= wdata_i[NPINS-1:0];
        `OFF_OPEN_SOURCE: osrc <= wdata_i[NPINS-1:0];
        `OFF_FILTER_EN: filt_en <= wdata_i[NPINS-1:0];
        `OFF_RISE_EN: rise_en <= wdata_i[NPINS-1:0];
        `OFF_FALL_EN: fall_en <= wdata_i[NPINS-1:0];
        `OFF_INT_MASK: mask <= wdata_i[NPINS-1:0];
        // Non-designated pins can never be armed for shutdown wake
        `OFF_WAKE_EN: wake_en <= wdata_i[NPINS-1:0] & WAKE_PINS[NPINS-1:0];
        default: begin
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCONN; g++) begin : g_route
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          route_sel[g] <= `ROUTE_SEL_W'(`RST_WORD);
          route_en[g] <= 1'b0;
        end else if (we_i && addr_i == 8'(`OFF_ROUTE0 + 4 * g)) begin
          route_sel[g] <= wdata_i[`ROUTE_SEL_W-1:0];
          route_en[g] <= wdata_i[`ROUTE_EN_BIT];
        end
      end

      // Out-of-range selections read back as a low level
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          conn_in_o[g] <= 1'b0;
        end else begin
          conn_in_o[g] <= (32'(route_sel[g]) < NPINS) ? lvl[route_sel[g]] : 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Input path: synchroniser, glitch filter, level
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      sync1 <= NPINS'(`RST_WORD);
      sync2 <= NPINS'(`RST_WORD);
      lvl <= NPINS'(`RST_WORD);
      lvl_prev <= NPINS'(`RST_WORD);
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      lvl <= (filt_en & filt) | (~filt_en & sync2);
      lvl_prev <= lvl;
    end
  end

  assign peripheral_event_network_o = lvl;

  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      logic [FILT_LEN-1:0] hist;
      logic ovr_hit;
      logic ovr_val;
      logic ovr_dir;
      logic src_val;
      logic src_dir;

      // A pulse shorter than FILT_LEN samples never reaches the level
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          hist <= FILT_LEN'(`RST_WORD);
          filt[g] <= 1'b0;
        end else begin
          hist <= {hist[FILT_LEN-2:0], sync2[g]};
          if (&hist) begin
            filt[g] <= 1'b1;
          end else if (~|hist) begin
            filt[g] <= 1'b0;
          end
        end
      end

      // Lowest-numbered connection wins when two select the same pin
      always_comb begin
        ovr_hit = 1'b0;
        ovr_val = 1'b0;
        ovr_dir = 1'b0;
        for (int c = NCONN - 1; c >= 0; c--) begin
          if (route_en[c] && 32'(route_sel[c]) == g) begin
            ovr_hit = 1'b1;
            ovr_val = conn_out_i[c];
            ovr_dir = conn_oe_i[c];
          end
        end
        src_val = ovr_hit ? ovr_val : out[g];
        src_dir = ovr_hit ? ovr_dir : dir[g];
        if (odrain[g]) begin
          next_o[g] = 1'b0;
          next_oe[g] = src_dir & ~src_val;
        end else if (osrc[g]) begin
          next_o[g] = 1'b1;
          next_oe[g] = src_dir & src_val;
        end else begin
          next_o[g] = src_val;
          next_oe[g] = src_dir;
        end
      end
      assign ovr[g] = ovr_hit;
      assign ab_mask[g] = (g < AB_PINS);

      // C/D pins keep their last value while asleep; A/B stay live in deep sleep but also hold in shutdown
      always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
          pin_o[g] <= 1'b0;
          pin_oe_o[g] <= 1'b0;
        end else if (pwr_state == PWR_RUN || (g < AB_PINS && pwr_state == PWR_DEEP)) begin
          pin_o[g] <= next_o[g];
          pin_oe_o[g] <= next_oe[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Power state tracking
  // ----------------------------------------------------------------
  always_comb begin
    case (pwr_state)
      PWR_RUN, PWR_DEEP, PWR_SHUT: begin
        if (shutdown_mode_i) begin
          next_pwr_state = PWR_SHUT;
        end else if (deep_sleep_mode_i || stop_mode_i) begin
          next_pwr_state = PWR_DEEP;
        end else begin
          next_pwr_state = PWR_RUN;
        end
      end
      default: next_pwr_state = PWR_RUN;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      pwr_state <= PWR_RUN;
    end else begin
      pwr_state <= next_pwr_state;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt and wake flags
  // ----------------------------------------------------------------
  // Edge detect runs on the always-on clock, so no module clock gate can hide it
  assign edge_set = (rise_en & lvl & ~lvl_prev) | (fall_en & ~lvl & lvl_prev);
  assign edge_any = lvl ^ lvl_prev;
  assign flag_rd = re_i && addr_i == `OFF_INT_FLAG;
  assign wake_rd = re_i && addr_i == `OFF_WAKE_STAT;
  assign flag_wclr = (we_i && addr_i == `OFF_INT_FLAG) ? wdata_i[NPINS-1:0] : NPINS'(`RST_WORD);
  assign wake_wclr = (we_i && addr_i == `OFF_WAKE_STAT) ? wdata_i[NPINS-1:0] : NPINS'(`RST_WORD);

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      flag <= NPINS'(`RST_WORD);
    end else begin
      // Set beats a clear arriving in the same cycle
      flag <= (flag & ~(flag_wclr | {NPINS{flag_rd}})) | edge_set;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      wake_flag <= NPINS'(`RST_WORD);
    end else begin
      wake_flag <= (wake_flag & ~(wake_wclr | {NPINS{wake_rd}}))
        | ((pwr_state == PWR_SHUT) ? (edge_any & wake_en) : NPINS'(`RST_WORD));
    end
  end

  assign irq_o = |(flag & mask);
  assign wake_o = (pwr_state == PWR_DEEP) && |(flag & mask & ab_mask);
  assign shutdown_wake_o = |wake_flag;

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!nrst_i) begin
      rdata_o <= `RST_WORD;
    end else if (re_i) begin
      rdata_o <= `RST_WORD;
      case (addr_i)
        `OFF_DIR: rdata_o[NPINS-1:0] <= dir;
        `OFF_OUT: rdata_o[NPINS-1:0] <= out;
        `OFF_OPEN_DRAIN: rdata_o[NPINS-1:0] <= odrain;
        `OFF_OPEN_SOURCE: rdata_o[NPINS-1:0] <= osrc;
        `OFF_FILTER_EN: rdata_o[NPINS-1:0] <= filt_en;
        `OFF_PIN_LEVEL: rdata_o[NPINS-1:0] <= lvl;
        `OFF_RISE_EN: rdata_o[NPINS-1:0] <= rise_en;
        `OFF_FALL_EN: rdata_o[NPINS-1:0] <= fall_en;
        `OFF_INT_FLAG: rdata_o[NPINS-1:0] <= flag;
        `OFF_INT_MASK: rdata_o[NPINS-1:0] <= mask;
        `OFF_WAKE_EN: rdata_o[NPINS-1:0] <= wake_en;
        `OFF_WAKE_STAT: rdata_o[NPINS-1:0] <= wake_flag;
        `OFF_POWER_STAT: rdata_o[1:0] <= pwr_state;
        default: begin
          for (int c = 0; c < NCONN; c++) begin
            if (addr_i == 8'(`OFF_ROUTE0 + 4 * c)) begin
              rdata_o[`ROUTE_SEL_W-1:0] <= route_sel[c];
              rdata_o[`ROUTE_EN_BIT] <= route_en[c];
            end
          end
        end
      endcase
    end else begin
      rdata_o <= `RST_WORD;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_dir_drives_oe: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (pwr_state == PWR_RUN && !ovr[1] && !odrain[1] && !osrc[1]) |=> pin_oe_o[1] == $past(dir[1]))
    else $error("pin 1 enable does not follow direction");

  a_open_drain_low: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (pwr_state == PWR_RUN && odrain[2]) |=> !(pin_oe_o[2] && pin_o[2]))
    else $error("open-drain pin driven high");

  a_conn_override: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (pwr_state == PWR_RUN && route_en[0] && route_sel[0] == 5 && !odrain[5] && !osrc[5])
    |=> (pin_oe_o[5] == $past(conn_oe_i[0]) && pin_o[5] == $past(conn_out_i[0])))
    else $error("connection did not override pin 5");

  a_route_input: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (route_en[1] && 32'(route_sel[1]) < NPINS) |=> conn_in_o[1] == $past(lvl[route_sel[1]]))
    else $error("routed input not taken from selected pin");

  a_event_latency: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (!filt_en[0])[*4] |-> peripheral_event_network_o[0] == $past(pin_i[0], 3))
    else $error("event level not three cycles behind pin");

  a_edge_irq: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (lvl[0] && !lvl_prev[0] && rise_en[0] && mask[0]) |=> irq_o)
    else $error("masked-in rising edge gave no interrupt");

  a_ab_live_deep: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (pwr_state == PWR_DEEP) |=> (pin_oe_o[1] == $past(next_oe[1]) && pin_o[1] == $past(next_o[1])))
    else $error("port A pin frozen in deep sleep");

  a_cd_frozen: assert property (@(posedge clock_i) disable iff (!nrst_i)
    ($past(pwr_state) != PWR_RUN) |-> ($stable(pin_oe_o & ~ab_mask) && $stable(pin_o & ~ab_mask)))
    else $error("port C/D pin changed while asleep");

  a_shut_wake: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (pwr_state == PWR_SHUT && |(edge_any & wake_en)) |=> shutdown_wake_o)
    else $error("designated pin edge gave no shutdown wake");

  a_flag_sticky: assert property (@(posedge clock_i) disable iff (!nrst_i)
    (flag[6] && !flag_rd && !flag_wclr[6]) |=> flag[6])
    else $error("interrupt flag dropped without a clear");

endmodule

/* gpio_board_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Board side of the pins
// ----------------------------------------------------------------
module gpio_board_model #(
  parameter int NPINS = 26
) (
  input wire logic [NPINS-1:0] pin_val_i,
  input wire logic [NPINS-1:0] pin_oe_i,
  input wire logic [NPINS-1:0] ext_en_i,
  input wire logic [NPINS-1:0] ext_val_i,
  output logic [NPINS-1:0] level_o
);
  // Device drive wins over the board; an undriven pin sits on its pull-down
  assign level_o = (pin_oe_i & pin_val_i) | (~pin_oe_i & ext_en_i & ext_val_i);
endmodule

/* general_purpose_pin_port_bench.sv */
`timescale 1ns/1ps
`include "gpio_port_params.svh"
module general_purpose_pin_port_bench;
  localparam int NP = 26;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic [3:0] conn_out = 4'h0;
  logic [3:0] conn_oe = 4'h0;
  logic deep = 1'b0;
  logic stop = 1'b0;
  logic shut = 1'b0;
  logic [NP-1:0] ext_en = '0;
  logic [NP-1:0] ext_val = '0;
  logic [31:0] rdata;
  logic [NP-1:0] pin_lvl, pin_val, pin_oe, evt;
  logic [3:0] conn_in;
  logic irq, wake, shut_wake;
  logic [31:0] d;
  int mismatches = 0;
  int compares = 0;

  general_purpose_pin_port dut (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .pin_i(pin_lvl), .pin_o(pin_val), .pin_oe_o(pin_oe),
    .conn_out_i(conn_out), .conn_oe_i(conn_oe), .conn_in_o(conn_in), .peripheral_event_network_o(evt),
    .deep_sleep_mode_i(deep), .stop_mode_i(stop), .shutdown_mode_i(shut), .irq_o(irq), .wake_o(wake),
    .shutdown_wake_o(shut_wake));
  gpio_board_model #(.NPINS(NP)) board (.pin_val_i(pin_val), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
    .ext_val_i(ext_val), .level_o(pin_lvl));

  initial begin
    forever #2.5 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------
  // Bus, drive and compare helpers
  // ----------------------------------------------------------------
  task end_sim;
    if (mismatches == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    wdata <= v;
    we <= 1'b1;
    @(posedge clock_i);
    we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clock_i);
    addr <= a;
    re <= 1'b1;
    @(posedge clock_i);
    re <= 1'b0;
    #1 v = rdata;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task drive(input int k, input logic v);
    @(posedge clock_i);
    ext_en[k] <= 1'b1;
    ext_val[k] <= v;
  endtask
  task wait_irq;
    int i;
    for (i = 0; i < 20 && irq !== 1'b1; i++) cyc(1);
    if (irq !== 1'b1) begin
      mismatches++;
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    int a;
    chk(pin_oe, '0);
    wr(8'h3C, 32'hFFFF_FFFF);
    for (a = 0; a <= 8'h3C; a += 4) begin
      rd(a[7:0], d);
      chk(d, 32'h0);
    end
  endtask
  task t_drive_modes;
    wr(`OFF_DIR, 32'h0010_000E);
    wr(`OFF_OPEN_DRAIN, 32'h0000_0004);
    wr(`OFF_OPEN_SOURCE, 32'h0000_0008);
    wr(`OFF_OUT, 32'h0010_000A);
    cyc(2);
    chk(pin_oe[3:1], 3'h7);
    chk(pin_val[3:1], 3'h5);
    wr(`OFF_OUT, 32'h0010_000E);
    cyc(5);
    chk(pin_oe[3:1], 3'h5);
    rd(`OFF_PIN_LEVEL, d);
    chk(d[1], 1'b1);
  endtask
  task t_filter;
    wr(`OFF_FILTER_EN, 32'h0000_0010);
    drive(4, 1'b1);
    drive(4, 1'b0);
    cyc(8);
    chk(evt[4], 1'b0);
    drive(4, 1'b1);
    cyc(9);
    chk(evt[4], 1'b1);
  endtask
  task t_route;
    @(posedge clock_i);
    conn_out <= 4'h1;
    conn_oe <= 4'h1;
    wr(`OFF_ROUTE0, 32'h0000_0105);
    cyc(2);
    chk({pin_oe[5], pin_val[5]}, 2'h3);
    cyc(5);
    chk(conn_in[0], 1'b1);
    wr(`OFF_ROUTE0 + 8'h04, 32'h0000_0119);
    drive(25, 1'b1);
    cyc(7);
    chk(conn_in[1], 1'b1);
  endtask
  task t_irq;
    wr(`OFF_RISE_EN, 32'h0000_0041);
    wr(`OFF_INT_MASK, 32'h0000_0001);
    drive(0, 1'b1);
    drive(6, 1'b1);
    wait_irq();
    chk(evt[0], 1'b1);
    drive(0, 1'b0);
    cyc(6);
    chk(irq, 1'b1);
    rd(`OFF_INT_FLAG, d);
    chk(d, 32'h0000_0041);
    chk(irq, 1'b0);
    rd(`OFF_INT_FLAG, d);
    chk(d, 32'h0);
    wr(`OFF_FALL_EN, 32'h0000_0040);
    drive(6, 1'b0);
    cyc(6);
    wr(`OFF_INT_FLAG, 32'h0000_0001);
    rd(`OFF_INT_FLAG, d);
    chk(d, 32'h0000_0040);
    drive(6, 1'b1);
    cyc(6);
    wr(`OFF_INT_FLAG, 32'h0000_0040);
    rd(`OFF_INT_FLAG, d);
    chk(d, 32'h0);
  endtask
  task t_sleep;
    @(posedge clock_i);
    stop <= 1'b1;
    cyc(3);
    rd(`OFF_POWER_STAT, d);
    chk(d, 32'h1);
    @(posedge clock_i);
    stop <= 1'b0;
    deep <= 1'b1;
    cyc(3);
    wr(`OFF_OUT, 32'h0000_000C);
    cyc(3);
    chk({pin_val[20], pin_val[1]}, 2'h2);
    drive(0, 1'b1);
    wait_irq();
    chk(wake, 1'b1);
    rd(`OFF_INT_FLAG, d);
    @(posedge clock_i);
    deep <= 1'b0;
    cyc(4);
    chk(pin_val[20], 1'b0);
  endtask
  task t_shutdown;
    wr(`OFF_WAKE_EN, 32'hFFFF_FFFF);
    rd(`OFF_WAKE_EN, d);
    chk(d, 32'h0000_0C03);
    @(posedge clock_i);
    shut <= 1'b1;
    cyc(3);
    drive(12, 1'b1);
    cyc(8);
    chk(shut_wake, 1'b0);
    drive(10, 1'b1);
    cyc(8);
    chk(shut_wake, 1'b1);
    rd(`OFF_POWER_STAT, d);
    chk(d, 32'h2);
  endtask

  initial begin
    #200000;
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_reset();
    t_drive_modes();
    t_filter();
    t_route();
    t_irq();
    t_sleep();
    t_shutdown();
    end_sim();
  end
endmodule
